// >>> verilog/timer16_waveform_ctrl.sv
// Purpose: Mode decode, counter and compare outputs of a 16-bit timer.
// Assumes: Counter steps once per ref_clk; no prescaler, no input capture.
// Notes: Register map on a classic Wishbone slave, one word per register.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform_ctrl
  import timer16_pkg::*;
  (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [1:0] compareOut,
  output logic [1:0] compareOe,
  output logic [1:0] compareOverride,
  output logic overflowFlag
  );
  logic [7:0] ctrlA_ff;
  logic [7:0] nxt_ctrlA;
  logic [1:0] wgmHi_ff;
  logic [1:0] nxt_wgmHi;
  logic [15:0] cmpBuf_ff [2];
  logic [15:0] nxt_cmpBuf [2];
  logic [15:0] cmp_ff [2];
  logic [15:0] nxt_cmp [2];
  logic [15:0] capture_ff;
  logic [15:0] nxt_capture;
  logic [1:0] dir_ff;
  logic [1:0] nxt_dir;
  logic ovf_ff;
  logic nxt_ovf;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic [31:0] rdMux;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic countUp_ff;
  logic nxt_countUp;
  logic [1:0] override_ff;
  logic [1:0] nxt_override;
  logic [1:0] oe_ff;
  logic [1:0] nxt_oe;
  logic busReq;
  logic [3:0] waveMode;
  kind_t kind;
  logic [15:0] topVal;
  slope_t slope;
  logic ovfEvent;
  logic loadCmp;
  logic [1:0] chanMode [2];
  hit_t hit [2];
  logic [1:0] waveBits;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
  endfunction : merge16

  assign waveMode = {wgmHi_ff, ctrlA_ff[1:0]};
  assign chanMode[0] = ctrlA_ff[CHA_LSB +: 2];
  assign chanMode[1] = ctrlA_ff[CHB_LSB +: 2];
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_ff;

  // Mode decode into counting kind and TOP source
  always_comb begin
    kind = KIND_RSVD;
    unique case (waveMode)
      MODE_NORMAL: kind = KIND_NORMAL;
      MODE_CTC_OCR, MODE_CTC_CAP: kind = KIND_CTC;
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_OCR: kind = KIND_PHASE;
      MODE_PFC_CAP, MODE_PFC_OCR: kind = KIND_PFC;
      MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP, MODE_FAST_OCR: kind = KIND_FAST;
      MODE_RSVD: kind = KIND_RSVD;
    endcase
  end

  always_comb begin
    topVal = MAX_VAL;
    unique case (waveMode)
      MODE_NORMAL, MODE_RSVD: topVal = MAX_VAL;
      MODE_PC8, MODE_FAST8: topVal = TOP_8;
      MODE_PC9, MODE_FAST9: topVal = TOP_9;
      MODE_PC10, MODE_FAST10: topVal = TOP_10;
      MODE_CTC_OCR, MODE_PFC_OCR, MODE_PC_OCR, MODE_FAST_OCR: topVal = cmp_ff[0];
      MODE_CTC_CAP, MODE_PFC_CAP, MODE_PC_CAP, MODE_FAST_CAP: topVal = capture_ff;
    endcase
  end

  assign slope.atTop = (cnt_ff == topVal);
  assign slope.atBottom = (cnt_ff == BOTTOM_VAL);
  assign slope.countUp = countUp_ff;

  // Counter, overflow event and compare update point
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_countUp = countUp_ff;
    ovfEvent = 1'b0;
    loadCmp = 1'b0;
    unique case (kind)
      KIND_NORMAL, KIND_CTC: begin
        nxt_cnt = slope.atTop ? BOTTOM_VAL : cnt_ff + 16'h0001;
        nxt_countUp = 1'b1;
        ovfEvent = (cnt_ff == MAX_VAL);
        loadCmp = 1'b1;
      end
      KIND_FAST: begin
        nxt_cnt = slope.atTop ? BOTTOM_VAL : cnt_ff + 16'h0001;
        nxt_countUp = 1'b1;
        ovfEvent = slope.atTop;
        loadCmp = slope.atTop;
      end
      KIND_PHASE, KIND_PFC: begin
        // A TOP lowered below the count turns the slope at once
        if (countUp_ff && cnt_ff >= topVal) begin
          nxt_countUp = 1'b0;
          nxt_cnt = cnt_ff - 16'h0001;
        end else if (countUp_ff || slope.atBottom) begin
          nxt_countUp = 1'b1;
          nxt_cnt = cnt_ff + 16'h0001;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
        ovfEvent = slope.atBottom && !countUp_ff;
        loadCmp = (kind == KIND_PFC) ? slope.atBottom : slope.atTop;
      end
      KIND_RSVD: begin
        nxt_cnt = BOTTOM_VAL;
        nxt_countUp = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= BOTTOM_VAL;
      countUp_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      countUp_ff <= nxt_countUp;
    end
  end

  // Read data mux
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CTRL_A: rdMux = {24'h000000, ctrlA_ff & CTRL_A_WMASK};
      OFS_CTRL_B: rdMux = {27'h0000000, wgmHi_ff, 3'h0};
      OFS_CMP_A: rdMux = {16'h0000, cmpBuf_ff[0]};
      OFS_CMP_B: rdMux = {16'h0000, cmpBuf_ff[1]};
      OFS_CAPTURE: rdMux = {16'h0000, capture_ff};
      OFS_DIRECTION: rdMux = {30'h00000000, dir_ff};
      OFS_STATUS: rdMux = {31'h00000000, ovf_ff};
      OFS_COUNTER: rdMux = {16'h0000, cnt_ff};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Register file and bus answer
  always_comb begin
    nxt_ctrlA = ctrlA_ff;
    nxt_wgmHi = wgmHi_ff;
    nxt_cmpBuf = cmpBuf_ff;
    nxt_cmp = cmp_ff;
    nxt_capture = capture_ff;
    nxt_dir = dir_ff;
    nxt_ovf = ovf_ff;
    nxt_ack = busReq;
    nxt_rd = rd_ff;
    if (busReq && !wb_we_i) begin
      nxt_rd = rdMux;
    end
    if (busReq && wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL_A: if (wb_sel_i[0]) nxt_ctrlA = wb_dat_i[7:0] & CTRL_A_WMASK;
        OFS_CTRL_B: if (wb_sel_i[0]) nxt_wgmHi = wb_dat_i[WGM_HI_LSB +: 2];
        OFS_CMP_A: nxt_cmpBuf[0] = merge16(cmpBuf_ff[0], wb_dat_i, wb_sel_i);
        OFS_CMP_B: nxt_cmpBuf[1] = merge16(cmpBuf_ff[1], wb_dat_i, wb_sel_i);
        OFS_CAPTURE: nxt_capture = merge16(capture_ff, wb_dat_i, wb_sel_i);
        OFS_DIRECTION: if (wb_sel_i[0]) nxt_dir = wb_dat_i[1:0];
        OFS_STATUS: if (wb_sel_i[0] && wb_dat_i[0]) nxt_ovf = 1'b0;
        default: nxt_ovf = nxt_ovf;
      endcase
    end
    // A new overflow beats a clear in the same cycle
    if (ovfEvent) begin
      nxt_ovf = 1'b1;
    end
    if (loadCmp) begin
      nxt_cmp = cmpBuf_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrlA_ff <= CTRL_A_RST;
      wgmHi_ff <= WGM_HI_RST;
      cmpBuf_ff <= '{VAL_RST, VAL_RST};
      cmp_ff <= '{VAL_RST, VAL_RST};
      capture_ff <= VAL_RST;
      dir_ff <= DIR_RST;
      ovf_ff <= 1'b0;
      ack_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
    end else begin
      ctrlA_ff <= nxt_ctrlA;
      wgmHi_ff <= nxt_wgmHi;
      cmpBuf_ff <= nxt_cmpBuf;
      cmp_ff <= nxt_cmp;
      capture_ff <= nxt_capture;
      dir_ff <= nxt_dir;
      ovf_ff <= nxt_ovf;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
    end
  end

  // Pin ownership and driver enable
  always_comb begin
    nxt_override[0] = |chanMode[0];
    nxt_override[1] = |chanMode[1];
    nxt_oe = nxt_override & dir_ff;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      override_ff <= 2'b00;
      oe_ff <= 2'b00;
    end else begin
      override_ff <= nxt_override;
      oe_ff <= nxt_oe;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gen_chan
    assign hit[g].match = (cnt_ff == cmp_ff[g]);
    assign hit[g].cmpAtTop = (cmp_ff[g] == topVal);
    assign hit[g].cmpAtBottom = (cmp_ff[g] == BOTTOM_VAL);
    compare_channel #(.CHAN_A(g == 0)) u_chan (
      .ref_clk(ref_clk),
      .reset(reset),
      .kind(kind),
      .waveMode(waveMode),
      .outMode(chanMode[g]),
      .slope(slope),
      .hit(hit[g]),
      .waveBit(waveBits[g])
    );
  end

  assign wb_dat_o = rd_ff;
  assign wb_ack_o = ack_ff;
  assign compareOut = waveBits;
  assign compareOe = oe_ff;
  assign compareOverride = override_ff;
  assign overflowFlag = ovf_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence upMatchA;
    kind inside {KIND_PHASE, KIND_PFC} && chanMode[0] == 2'b10 && hit[0].match
      && countUp_ff && !hit[0].cmpAtTop && !hit[0].cmpAtBottom;
  endsequence

  sequence fastTopA;
    kind == KIND_FAST && slope.atTop && chanMode[0][1];
  endsequence

  bus_ack_a: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  pin_own_a_a: assert property (##1 compareOverride[0] == |$past(chanMode[0]))
    else $error("channel A pin ownership wrong");
  pin_own_b_a: assert property (##1 compareOverride[1] == |$past(chanMode[1]))
    else $error("channel B pin ownership wrong");
  drv_dir_a: assert property (compareOe[0] |-> $past(dir_ff[0]) && compareOverride[0])
    else $error("driver enabled without direction");
  rsvd_read_a: assert property (wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == OFS_CTRL_A |-> wb_dat_o[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  up_clear_a: assert property (upMatchA |=> !compareOut[0])
    else $error("up-count match did not clear output");
  fast_top_a: assert property (fastTopA ##0 chanMode[0][0] == 1'b0 |=> compareOut[0])
    else $error("fast PWM output not set at TOP");
  fast_inv_a: assert property (fastTopA ##0 chanMode[0][0] |=> !compareOut[0])
    else $error("inverted fast PWM output not cleared at TOP");
  fast_ovf_a: assert property (kind == KIND_FAST && slope.atTop |=> overflowFlag)
    else $error("overflow missing at TOP in fast PWM");
  dual_ovf_a: assert property (kind inside {KIND_PHASE, KIND_PFC} && slope.atBottom
      && !countUp_ff |=> overflowFlag)
    else $error("overflow missing at BOTTOM in dual slope");
  norm_wrap_a: assert property (kind == KIND_NORMAL && cnt_ff == MAX_VAL
      |=> cnt_ff == BOTTOM_VAL && overflowFlag)
    else $error("normal mode did not wrap at MAX");
  rsvd_hold_a: assert property (kind == KIND_RSVD [*2] |-> cnt_ff == BOTTOM_VAL
      && $stable(compareOut))
    else $error("reserved mode moved counter or outputs");
endmodule : timer16_waveform_ctrl
`default_nettype wire

// >>> common/timer16_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer waveform control.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes: Registers are one aligned word each, narrow data in the low bits.
package timer16_pkg;
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_CTRL_A = 5'h00;
  localparam logic [4:0] OFS_CTRL_B = 5'h04;
  localparam logic [4:0] OFS_CMP_A = 5'h08;
  localparam logic [4:0] OFS_CMP_B = 5'h0c;
  localparam logic [4:0] OFS_CAPTURE = 5'h10;
  localparam logic [4:0] OFS_DIRECTION = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam logic [4:0] OFS_COUNTER = 5'h1c;
  localparam int CHA_LSB = 6;
  localparam int CHB_LSB = 4;
  localparam int WGM_HI_LSB = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [1:0] WGM_HI_RST = 2'h0;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_OCR = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_OCR = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_PC_OCR = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] MODE_RSVD = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_OCR = 4'hf;
  typedef enum logic [2:0] {
    KIND_NORMAL, KIND_CTC, KIND_PHASE, KIND_PFC, KIND_FAST, KIND_RSVD
  } kind_t;
  typedef struct packed {
    logic atTop;
    logic atBottom;
    logic countUp;
  } slope_t;
  typedef struct packed {
    logic match;
    logic cmpAtTop;
    logic cmpAtBottom;
  } hit_t;
endpackage : timer16_pkg

// >>> verilog/compare_channel.sv
// Purpose: Waveform bit of one compare channel.
// Assumes: Events come from the counter of the parent, one per clock.
// Notes: Channel A alone may toggle in the PWM modes.
`timescale 1ns/100ps
`default_nettype none
module compare_channel
  import timer16_pkg::*;
  #(parameter bit CHAN_A = 1'b1)
  (
  input wire logic ref_clk,
  input wire logic reset,
  input wire kind_t kind,
  input wire logic [3:0] waveMode,
  input wire logic [1:0] outMode,
  input wire slope_t slope,
  input wire hit_t hit,
  output logic waveBit
  );
  logic wave_ff;
  logic nxt_wave;
  logic fastToggle;
  logic dualToggle;

  assign fastToggle = CHAN_A && (waveMode == MODE_FAST_CAP || waveMode == MODE_FAST_OCR);
  assign dualToggle = CHAN_A && waveMode >= MODE_PFC_CAP && waveMode <= MODE_PC_OCR;

  always_comb begin
    nxt_wave = wave_ff;
    unique case (kind)
      KIND_NORMAL, KIND_CTC: begin
        if (hit.match && outMode == 2'b01) begin
          nxt_wave = ~wave_ff;
        end else if (hit.match && outMode[1]) begin
          nxt_wave = outMode[0];
        end
      end
      KIND_FAST: begin
        if (outMode == 2'b01) begin
          if (fastToggle && hit.match) begin
            nxt_wave = ~wave_ff;
          end
        end else if (outMode[1]) begin
          // TOP checked first, so a compare at TOP is dropped
          if (slope.atTop) begin
            nxt_wave = ~outMode[0];
          end else if (hit.match) begin
            nxt_wave = outMode[0];
          end
        end
      end
      KIND_PHASE, KIND_PFC: begin
        if (outMode == 2'b01) begin
          if (dualToggle && hit.match) begin
            nxt_wave = ~wave_ff;
          end
        end else if (outMode[1] && hit.match) begin
          if (hit.cmpAtBottom) begin
            nxt_wave = outMode[0];
          end else if (hit.cmpAtTop) begin
            nxt_wave = ~outMode[0];
          end else if (slope.countUp) begin
            nxt_wave = outMode[0];
          end else begin
            nxt_wave = ~outMode[0];
          end
        end
      end
      KIND_RSVD: nxt_wave = wave_ff;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  assign waveBit = wave_ff;
endmodule : compare_channel
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the 16-bit timer waveform control.
// Assumes: Classic Wishbone slave, ack one cycle after a request is taken.
// Notes: Mode 13 parks the counter at 0 between scenarios, so no count runs away.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  import timer16_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [ADR_W-1:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [1:0] cOut;
  logic [1:0] cOe;
  logic [1:0] cOvr;
  logic ovf;
  int miscompares = 0;
  int checks = 0;
  int seed = 11993;
  int hi [2];
  int tg [2];
  // mode, compare A, capture, compare B, mode field A, mode field B, toggles A, toggles B
  int tgl [7][8] = '{'{4, 49, 0, 10, 1, 1, 10, 10}, '{15, 49, 0, 10, 1, 1, 10, 0},
    '{14, 10, 49, 20, 1, 1, 10, 0}, '{5, 100, 0, 10, 1, 1, 0, 0},
    '{9, 25, 0, 10, 1, 1, 10, 0}, '{11, 25, 0, 10, 1, 1, 10, 0}, '{1, 10, 0, 10, 1, 1, 0, 0}};
  int ofm [11] = '{1, 5, 6, 8, 9, 10, 11, 14, 15, 4, 12};

  always #4 ref_clk = ~ref_clk;

  timer16_waveform_ctrl dut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .compareOut(cOut), .compareOe(cOe), .compareOverride(cOvr), .overflowFlag(ovf)
  );

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    `CHK(ack, 1'h1)
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    `CHK(q, exp)
  endtask : rd

  task automatic setMode(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb);
    bus(1'h1, OFS_CTRL_B, {27'h0, m[3:2], 3'h0});
    // Bits 3:2 written as ones on purpose, they must read back zero
    bus(1'h1, OFS_CTRL_A, {24'h0, ca, cb, 2'h3, m[1:0]});
  endtask : setMode

  task automatic park();
    setMode(MODE_RSVD, 2'h0, 2'h0);
  endtask : park

  task automatic wrVals(input int a, input int cap, input int b);
    bus(1'h1, OFS_CMP_A, 32'(a));
    bus(1'h1, OFS_CMP_B, 32'(b));
    bus(1'h1, OFS_CAPTURE, 32'(cap));
  endtask : wrVals

  task automatic meas(input int n);
    logic [1:0] prev;
    hi = '{0, 0};
    tg = '{0, 0};
    @(negedge ref_clk);
    prev = cOut;
    repeat (n) begin
      @(negedge ref_clk);
      for (int b = 0; b < 2; b++) begin
        hi[b] += int'(cOut[b]);
        tg[b] += int'(cOut[b] != prev[b]);
      end
      prev = cOut;
    end
  endtask : meas

  // A whole period is measured, so the count does not depend on phase
  function automatic int fastHigh(input int c, input logic inv);
    return inv ? 255 - c : c + 1;
  endfunction : fastHigh

  function automatic int dualHigh(input int c, input logic inv, input int top);
    return inv ? 2 * top - 2 * c : 2 * c;
  endfunction : dualHigh

  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (110000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end

  initial begin
    int c;
    int k;
    logic [31:0] r;
    logic [3:0] m;
    logic inv;
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    @(negedge ref_clk);
    `CHK({cOut, cOe, cOvr, ovf}, 7'h00)
    for (k = 0; k <= 24; k += 4) begin
      rd(5'(k), 32'h0);
    end
    bus(1'h1, 5'h02, 32'hffff);
    rd(5'h02, 32'h0);
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      m = (r[3:0] == MODE_RSVD) ? MODE_CTC_OCR : r[3:0];
      setMode(m, r[7:6], r[5:4]);
      bus(1'h1, OFS_DIRECTION, {30'h0, r[9:8]});
      @(negedge ref_clk);
      `CHK(cOvr, {|r[5:4], |r[7:6]})
      `CHK(cOe, {|r[5:4], |r[7:6]} & r[9:8])
      rd(OFS_CTRL_A, {24'h0, r[7:6], r[5:4], 2'h0, m[1:0]});
      rd(OFS_CTRL_B, {27'h0, m[3:2], 3'h0});
    end
    park();
    repeat (5) @(negedge ref_clk);
    rd(OFS_COUNTER, 32'h0);
    meas(50);
    `CHK(tg[0] + tg[1], 0)
    for (k = 0; k < 7; k++) begin
      park();
      wrVals(tgl[k][1], tgl[k][2], tgl[k][3]);
      setMode(4'(tgl[k][0]), 2'(tgl[k][4]), 2'(tgl[k][5]));
      repeat (300) @(negedge ref_clk);
      meas(500);
      `CHK(tg[0], tgl[k][6])
      `CHK(tg[1], tgl[k][7])
    end
    park();
    wrVals(49, 0, 10);
    setMode(MODE_CTC_OCR, 2'h3, 2'h2);
    repeat (120) @(negedge ref_clk);
    `CHK(cOut, 2'h1)
    setMode(MODE_CTC_OCR, 2'h2, 2'h3);
    repeat (120) @(negedge ref_clk);
    `CHK(cOut, 2'h2)
    for (k = 0; k < 10; k++) begin
      c = $random(seed) & 255;
      inv = k[0];
      if (k == 2 || k == 3 || k == 7) begin
        c = 255;
      end
      if (k == 6) begin
        c = 0;
      end
      park();
      if (k < 4) begin
        wrVals(0, 0, c);
        setMode(MODE_FAST8, 2'h0, {1'h1, inv});
        repeat (520) @(negedge ref_clk);
        meas(256);
        `CHK(hi[1], fastHigh(c, inv))
      end else begin
        if (k > 7) begin
          c = c % 101;
        end
        wrVals(c, k > 7 ? 100 : 0, 0);
        setMode(k > 7 ? MODE_PFC_CAP : MODE_PC8, {1'h1, inv}, 2'h0);
        repeat (1040) @(negedge ref_clk);
        meas(k > 7 ? 200 : 510);
        `CHK(hi[0], dualHigh(c, inv, k > 7 ? 100 : 255))
      end
    end
    for (k = 0; k < 11; k++) begin
      park();
      bus(1'h1, OFS_STATUS, 32'h1);
      wrVals(100, 100, 0);
      setMode(4'(ofm[k]), 2'h0, 2'h0);
      repeat (600) @(negedge ref_clk);
      `CHK(ovf, 1'(ofm[k] != 4 && ofm[k] != 12))
    end
    // Full 16-bit wrap, the longest wait of the run
    park();
    bus(1'h1, OFS_STATUS, 32'h1);
    setMode(MODE_NORMAL, 2'h0, 2'h0);
    repeat (65400) @(negedge ref_clk);
    `CHK(ovf, 1'h0)
    repeat (300) @(negedge ref_clk);
    `CHK(ovf, 1'h1)
    rd(OFS_STATUS, 32'h1);
    bus(1'h1, OFS_STATUS, 32'h1);
    @(negedge ref_clk);
    `CHK(ovf, 1'h0)
    close_out();
  end
endmodule : testbench
`default_nettype wire
